// ### caw_pkg.sv
`default_nettype none

package caw_pkg;

  // ****************************************************************
  // Register addresses
  // ****************************************************************
  localparam logic [7:0] ADDR_CTRL    = 8'hd8;
  localparam logic [7:0] ADDR_MODE    = 8'hd9;
  localparam logic [7:0] ADDR_CPM5    = 8'hce;
  localparam logic [7:0] ADDR_CNT_LO  = 8'he9;
  localparam logic [7:0] ADDR_CNT_HI  = 8'hf9;
  localparam logic [7:0] ADDR_CPL5    = 8'hd3;
  localparam logic [7:0] ADDR_CPH5    = 8'hd4;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int CTRL_CF      = 7;
  localparam int CTRL_CR      = 6;
  localparam int CTRL_WDF     = 5;
  localparam int MODE_IDLE_SUSPEND    = 7;
  localparam int MODE_WATCHDOG_ENABLE_BIT    = 6;
  localparam int MODE_WATCHDOG_LOCK_BIT   = 5;
  localparam int MODE_UNUSED  = 4;
  localparam int MODE_CPS_LSB = 1;
  localparam int MODE_ECF     = 0;
  localparam int CPM_ECOM     = 6;
  localparam int CPM_MAT      = 3;
  localparam int CPM_ECCF     = 0;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [7:0]  CTRL_RST = 8'h00;
  localparam logic [7:0]  MODE_RST = 8'h40;
  localparam logic [15:0] CNT_RST  = 16'h0000;
  localparam logic [7:0]  CPL5_RST = 8'h00;
  localparam logic [7:0]  CPH5_RST = 8'h00;
  localparam logic [7:0]  CPM5_RST = 8'h00;

  // ****************************************************************
  // Timebase codes and timing
  // ****************************************************************
  localparam logic [2:0] TB_DIV12 = 3'h0;
  localparam logic [2:0] TB_DIV4  = 3'h1;
  localparam logic [2:0] TB_T0    = 3'h2;
  localparam logic [2:0] TB_ECI   = 3'h3;
  localparam logic [2:0] TB_SYS   = 3'h4;
  localparam logic [2:0] TB_EXT8  = 3'h5;

  localparam int CLK_PERIOD_NS   = 10;
  localparam int SYS_DIV_12      = 12;
  localparam int SYS_DIV_4       = 4;
  localparam int EXT_DIV         = 8;
  localparam int WDT_FIRST_TICKS = 256;
  localparam int WDT_FIRST_CYCLES = WDT_FIRST_TICKS * SYS_DIV_12;

endpackage : caw_pkg

`default_nettype wire

// ### caw_timebase.sv
`default_nettype none

module caw_timebase
  import caw_pkg::*;
(
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst,
  // Control
  input  wire logic       run,
  input  wire logic [2:0] sel,
  // Sources
  input  wire logic       timer0_ovf,
  input  wire logic       ext_count_in,
  input  wire logic       ext_clk_in,
  // Counter advance
  output logic            tick
);
  import caw_pkg::*;

  localparam logic [3:0] PRE_LAST_12 = 4'(SYS_DIV_12 - 1);
  localparam logic [3:0] PRE_LAST_4  = 4'(SYS_DIV_4 - 1);
  localparam logic [2:0] EXT_LAST    = 3'(EXT_DIV - 1);

  typedef struct packed {
    logic [3:0] pre;
    logic       eci_prev;
    logic       ext_prev;
    logic [2:0] ext_cnt;
  } caw_tb_state_t;

  caw_tb_state_t st_q;
  caw_tb_state_t st_d;

  // ****************************************************************
  // Source selection
  // ****************************************************************
  always_comb begin
    st_d          = st_q;
    tick          = 1'b0;
    st_d.eci_prev = ext_count_in;
    st_d.ext_prev = ext_clk_in;
    if (run) begin
      case (sel)
        TB_DIV12: begin
          tick     = (st_q.pre == PRE_LAST_12);
          st_d.pre = tick ? 4'h0 : 4'(st_q.pre + 4'h1);
        end
        TB_DIV4: begin
          tick     = (st_q.pre >= PRE_LAST_4);
          st_d.pre = tick ? 4'h0 : 4'(st_q.pre + 4'h1);
        end
        TB_T0:   tick = timer0_ovf;
        // Falling edge only; caller keeps the rate at or below div 4
        TB_ECI:  tick = st_q.eci_prev & ~ext_count_in;
        TB_SYS:  tick = 1'b1;
        TB_EXT8: begin
          if (ext_clk_in & ~st_q.ext_prev) begin
            tick         = (st_q.ext_cnt == EXT_LAST);
            st_d.ext_cnt = 3'(st_q.ext_cnt + 3'h1);
          end
        end
        // Reserved codes leave the counter still
        default: tick = 1'b0;
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  sys_tick_a: assert property (@(posedge ref_clk) disable iff (rst)
    (run && sel == TB_SYS) |-> tick)
    else $error("system clock timebase did not tick");

  div4_gap_a: assert property (@(posedge ref_clk) disable iff (rst)
    (tick && run && sel == TB_DIV4) ##1 (run && sel == TB_DIV4)
    |-> !tick)
    else $error("divide by four ticked twice in a row");

endmodule : caw_timebase

`default_nettype wire

// ### caw_wdt_ctrl.sv
`default_nettype none

module caw_wdt_ctrl (
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst,
  // Register access
  input  wire logic [7:0] sfr_addr,
  input  wire logic       sfr_wr_en,
  input  wire logic [7:0] sfr_wdata,
  output logic      [7:0] sfr_rdata,
  // Timebase sources
  input  wire logic       timer0_ovf,
  input  wire logic       ext_count_in,
  input  wire logic       ext_clk_in,
  // System state and other modules
  input  wire logic       cpu_idle,
  input  wire logic [4:0] module_match,
  input  wire logic [4:0] module_irq_en,
  // Requests
  output logic            array_irq,
  output logic            wdt_reset_req
);
  import caw_pkg::*;

  typedef struct packed {
    logic [15:0] cnt;
    logic        cf;
    logic        cr;
    logic [5:0]  ccf;
    logic        idle_suspend;
    logic        watchdog_enable_bit;
    logic        watchdog_lock_bit;
    logic [2:0]  cps;
    logic        ecf;
    logic [7:0]  cpl5;
    logic [7:0]  cph5;
    logic [7:0]  cpm5;
    logic [7:0]  rdata;
    logic        irq;
    logic        wrst;
  } caw_state_t;

  caw_state_t  st_q;
  caw_state_t  st_d;
  logic        active;
  logic        run_en;
  logic        tick;
  logic        timeout;
  logic        force_rst;
  logic [15:0] cnt_next;
  logic        m5_match;

  // ****************************************************************
  // Read decode
  // ****************************************************************
  function automatic logic [7:0] read_mux(input logic [7:0] a,
                                          input caw_state_t s);
    logic [7:0] r;
    r = 8'h00;
    if (a == ADDR_CTRL) begin
      r = {s.cf, s.cr, s.ccf};
    end else if (a == ADDR_MODE) begin
      r = {s.idle_suspend, s.watchdog_enable_bit, s.watchdog_lock_bit, 1'b0, s.cps, s.ecf};
    end else if (a == ADDR_CNT_LO) begin
      r = s.cnt[7:0];
    end else if (a == ADDR_CNT_HI) begin
      r = s.cnt[15:8];
    end else if (a == ADDR_CPL5) begin
      r = s.cpl5;
    end else if (a == ADDR_CPH5) begin
      r = s.cph5;
    end else if (a == ADDR_CPM5) begin
      r = s.cpm5;
    end
    return r;
  endfunction : read_mux

  assign active = st_q.watchdog_enable_bit | st_q.watchdog_lock_bit;
  // run bit, forced on by watchdog
  assign run_en = (st_q.cr | active) & ~(st_q.idle_suspend & cpu_idle);

  caw_timebase u_timebase (
    .ref_clk      (ref_clk),
    .rst          (rst),
    .run          (run_en),
    .sel          (st_q.cps),
    .timer0_ovf   (timer0_ovf),
    .ext_count_in (ext_count_in),
    .ext_clk_in   (ext_clk_in),
    .tick         (tick)
  );

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    st_d     = st_q;
    cnt_next = 16'(st_q.cnt + 16'h0001);
    // overflow of low byte at match
    timeout  = active & tick & (st_q.cnt[7:0] == 8'hff)
             & (st_q.cph5 == st_q.cnt[15:8]);
    // Module five acts as a plain software timer when not watching
    m5_match = ~active & tick & st_q.cpm5[CPM_ECOM]
             & st_q.cpm5[CPM_MAT] & (cnt_next == {st_q.cph5, st_q.cpl5});
    force_rst = 1'b0;
    if (tick) begin
      st_d.cnt = cnt_next;
    end
    if (sfr_wr_en) begin
      if (sfr_addr == ADDR_CTRL) begin
        st_d.cf  = sfr_wdata[CTRL_CF];
        st_d.cr  = sfr_wdata[CTRL_CR];
        st_d.ccf = sfr_wdata[5:0];
        force_rst = active & sfr_wdata[CTRL_WDF];
      end else if (sfr_addr == ADDR_MODE) begin
        // other mode bits locked by enable
        if (!st_q.watchdog_enable_bit) begin
          st_d.ecf   = sfr_wdata[MODE_ECF];
          st_d.watchdog_lock_bit = st_q.watchdog_lock_bit | sfr_wdata[MODE_WATCHDOG_LOCK_BIT];
          if (!active) begin
            st_d.idle_suspend = sfr_wdata[MODE_IDLE_SUSPEND];
            st_d.cps  = sfr_wdata[MODE_CPS_LSB +: 3];
          end
        end
        st_d.watchdog_enable_bit = sfr_wdata[MODE_WATCHDOG_ENABLE_BIT] | (st_q.watchdog_lock_bit & st_q.watchdog_enable_bit);
      end else if (sfr_addr == ADDR_CNT_LO) begin
        if (!active) begin
          st_d.cnt[7:0] = sfr_wdata;
        end
      end else if (sfr_addr == ADDR_CNT_HI) begin
        if (!active) begin
          st_d.cnt[15:8] = sfr_wdata;
        end
      end else if (sfr_addr == ADDR_CPL5) begin
        st_d.cpl5 = sfr_wdata;
      end else if (sfr_addr == ADDR_CPH5) begin
        // write while active loads high byte plus offset; inactive write loads the data
        st_d.cph5 = active ? 8'(st_q.cnt[15:8] + st_q.cpl5) : sfr_wdata;
      end else if (sfr_addr == ADDR_CPM5) begin
        if (!active) begin
          st_d.cpm5 = sfr_wdata;
        end
      end
    end
    // wrap sets flag; set beats a clear
    if (tick && st_q.cnt == 16'hffff) begin
      st_d.cf = 1'b1;
    end
    st_d.ccf = st_d.ccf | {m5_match, module_match};
    st_d.irq = (st_d.cf & st_d.ecf)
             | (|(st_d.ccf & {st_d.cpm5[CPM_ECCF], module_irq_en}));
    st_d.wrst  = timeout | force_rst;
    // run bit shows software value only
    st_d.rdata = read_mux(sfr_addr, st_q);
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st_q       <= '0;
      st_q.cf    <= CTRL_RST[CTRL_CF];
      st_q.cr    <= CTRL_RST[CTRL_CR];
      st_q.ccf   <= CTRL_RST[5:0];
      st_q.idle_suspend  <= MODE_RST[MODE_IDLE_SUSPEND];
      st_q.watchdog_enable_bit  <= MODE_RST[MODE_WATCHDOG_ENABLE_BIT];
      st_q.watchdog_lock_bit <= MODE_RST[MODE_WATCHDOG_LOCK_BIT];
      st_q.cps   <= MODE_RST[MODE_CPS_LSB +: 3];
      st_q.ecf   <= MODE_RST[MODE_ECF];
      st_q.cnt   <= CNT_RST;
      st_q.cpl5  <= CPL5_RST;
      st_q.cph5  <= CPH5_RST;
      st_q.cpm5  <= CPM5_RST;
    end else begin
      st_q <= st_d;
    end
  end

  assign sfr_rdata     = st_q.rdata;
  assign array_irq     = st_q.irq;
  assign wdt_reset_req = st_q.wrst;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  // Cycles since reset while software stays silent
  logic [12:0] chk_cyc_q;
  logic        chk_quiet_q;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      chk_cyc_q   <= 13'h0000;
      chk_quiet_q <= 1'b1;
    end else begin
      if (chk_cyc_q != 13'h1fff) begin
        chk_cyc_q <= 13'(chk_cyc_q + 13'h0001);
      end
      if (sfr_wr_en) begin
        chk_quiet_q <= 1'b0;
      end
    end
  end

  wdt_timeout_a: assert property (
    (active && tick && st_q.cnt[7:0] == 8'hff
     && st_q.cph5 == st_q.cnt[15:8]) |=> wdt_reset_req)
    else $error("timeout match gave no reset");

  force_reset_a: assert property (
    (active && sfr_wr_en && sfr_addr == ADDR_CTRL
     && sfr_wdata[CTRL_WDF]) |=> wdt_reset_req)
    else $error("forced reset missing");

  mode_freeze_a: assert property (
    (active && sfr_wr_en && sfr_addr == ADDR_MODE)
    |=> (st_q.cps == $past(st_q.cps) && st_q.idle_suspend == $past(st_q.idle_suspend)))
    else $error("timebase or idle changed while active");

  lock_active_a: assert property (
    st_q.watchdog_lock_bit |-> ##1 (st_q.watchdog_lock_bit && active))
    else $error("lock did not keep watchdog active");

  lock_hold_a: assert property (
    (st_q.watchdog_lock_bit && st_q.watchdog_enable_bit) |=> st_q.watchdog_enable_bit)
    else $error("enable cleared under lock");

  reset_val_a: assert property (@(posedge ref_clk)
    ($past(rst) && !rst) |-> (st_q.watchdog_enable_bit && st_q.cps == TB_DIV12
      && st_q.cnt[7:0] == 8'h00 && st_q.cpl5 == 8'h00))
    else $error("reset defaults wrong");

  first_timeout_a: assert property (
    (wdt_reset_req && chk_quiet_q)
    |-> chk_cyc_q == 13'(WDT_FIRST_CYCLES))
    else $error("first timeout at wrong cycle");

  cf_set_a: assert property (
    (tick && st_q.cnt == 16'hffff) |=> st_q.cf)
    else $error("wrap did not set overflow flag");

  cf_hold_a: assert property (
    (st_q.cf && !(sfr_wr_en && sfr_addr == ADDR_CTRL)) |=> st_q.cf)
    else $error("overflow flag cleared by hardware");

  // Flag, enable and request share one register edge
  cf_irq_a: assert property (
    (st_q.cf && st_q.ecf) |-> array_irq)
    else $error("overflow interrupt missing");

  run_stop_a: assert property (
    (!st_q.cr && !active && !sfr_wr_en) |=> st_q.cnt == $past(st_q.cnt))
    else $error("counter moved while stopped");

  match_flag_a: assert property (
    (|module_match) |=> ((st_q.ccf[4:0] & $past(module_match))
                         == $past(module_match)))
    else $error("match did not set module flag");

  idle_stop_a: assert property (
    (st_q.idle_suspend && cpu_idle && !sfr_wr_en) |=> st_q.cnt == $past(st_q.cnt))
    else $error("counter moved in suspended idle");

  mode_lock_a: assert property (
    (st_q.watchdog_enable_bit && sfr_wr_en && sfr_addr == ADDR_MODE)
    |=> (st_q.ecf == $past(st_q.ecf) && st_q.watchdog_lock_bit == $past(st_q.watchdog_lock_bit)))
    else $error("mode bits changed while enabled");

  unused_zero_a: assert property (
    (sfr_addr == ADDR_MODE) |=> !sfr_rdata[MODE_UNUSED])
    else $error("unused mode bit read as one");

  update_load_a: assert property (
    (active && sfr_wr_en && sfr_addr == ADDR_CPH5)
    |=> st_q.cph5 == 8'($past(st_q.cnt[15:8]) + $past(st_q.cpl5)))
    else $error("update register loaded wrong value");

  cnt_block_a: assert property (
    (active && !tick && sfr_wr_en
     && (sfr_addr == ADDR_CNT_LO || sfr_addr == ADDR_CNT_HI))
    |=> st_q.cnt == $past(st_q.cnt))
    else $error("counter written while active");

  run_read_a: assert property (
    (sfr_addr == ADDR_CTRL && !st_q.cr) |=> !sfr_rdata[CTRL_CR])
    else $error("run bit read as one");

  reset_cause_a: assert property (
    wdt_reset_req |-> $past(timeout || force_rst))
    else $error("reset request without cause");

  timeout_c: cover property (timeout ##1 wdt_reset_req);
  force_c:   cover property (force_rst);
  wrap_c:    cover property (tick && st_q.cnt == 16'hffff);
  lock_c:    cover property (st_q.watchdog_lock_bit && !st_q.watchdog_enable_bit);

endmodule : caw_wdt_ctrl

`default_nettype wire

// ### caw_wdt_ctrl_test.sv
`default_nettype none

module caw_wdt_ctrl_test;
  import caw_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;

  typedef struct {logic irq; logic [7:0] val;} caw_chk_t;

  logic       ref_clk       = 1'b0;
  logic       rst           = 1'b1;
  logic [7:0] sfr_addr      = 8'h00;
  logic       sfr_wr_en     = 1'b0;
  logic [7:0] sfr_wdata     = 8'h00;
  logic [7:0] sfr_rdata;
  logic       timer0_ovf    = 1'b0;
  logic       ext_count_in  = 1'b1;
  logic       ext_clk_in    = 1'b0;
  logic       cpu_idle      = 1'b0;
  logic [4:0] module_match  = 5'h00;
  logic [4:0] module_irq_en = 5'h00;
  logic       array_irq;
  logic       wdt_reset_req;
  logic       rd_chk        = 1'b0;
  logic [7:0] rnd;
  int         cyc           = 0;
  int         num_errors    = 0;
  int         n_compared    = 0;
  int         n0;
  caw_chk_t   chk_q[$];
  int         rst_at[$];
  int         rst_tol[$];
  logic [2:0] tb_code [5]   = '{TB_SYS, TB_T0, TB_ECI, TB_EXT8, TB_DIV4};
  int         tb_n [5]      = '{0, 2, 2, 16, 4};

  always #(CLK_PERIOD_NS / 2) ref_clk = ~ref_clk;

  caw_wdt_ctrl i_dut (
    .ref_clk(ref_clk), .rst(rst), .sfr_addr(sfr_addr),
    .sfr_wr_en(sfr_wr_en), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
    .timer0_ovf(timer0_ovf), .ext_count_in(ext_count_in),
    .ext_clk_in(ext_clk_in), .cpu_idle(cpu_idle),
    .module_match(module_match), .module_irq_en(module_irq_en),
    .array_irq(array_irq), .wdt_reset_req(wdt_reset_req)
  );

  // ****************************************************************
  // Output watcher
  // ****************************************************************
  always @(posedge ref_clk) begin : mon
    caw_chk_t   e;
    logic [7:0] got;
    if (rst) cyc <= 0;
    else cyc <= cyc + 1;
    if (!rst && rd_chk) begin
      e = chk_q.pop_front();
      got = e.irq ? {7'h00, array_irq} : sfr_rdata;
      n_compared++;
      if (got !== e.val) begin
        num_errors++;
        $display("CHECK FAILED %s expected %h seen %h",
                 e.irq ? "array_irq" : "sfr_rdata", e.val, got);
      end
    end
    if (!rst && wdt_reset_req !== 1'b0) begin
      n_compared++;
      if (rst_at.size() == 0 || wdt_reset_req !== 1'b1 ||
          cyc < rst_at[0] - rst_tol[0] || cyc > rst_at[0] + rst_tol[0]) begin
        num_errors++;
        $display("CHECK FAILED wdt_reset_req expected cycle %0d seen %0d",
                 rst_at.size() ? rst_at[0] : -1, cyc);
      end
      if (rst_at.size() != 0) begin
        void'(rst_at.pop_front());
        void'(rst_tol.pop_front());
      end
    end
  end

  // ****************************************************************
  // Bus and stimulus tasks
  // ****************************************************************
  task automatic report_and_stop();
    if (num_errors == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : report_and_stop

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr_en = 1'b1;
    @(negedge ref_clk);
    sfr_wr_en = 1'b0;
  endtask : wr

  task automatic pulse_chk();
    @(negedge ref_clk);
    rd_chk = 1'b1;
    @(negedge ref_clk);
    rd_chk = 1'b0;
  endtask : pulse_chk

  task automatic rd(input logic [7:0] a, input logic [7:0] v);
    @(negedge ref_clk);
    sfr_addr = a;
    chk_q.push_back('{1'b0, v});
    pulse_chk();
  endtask : rd

  task automatic irq_is(input logic v);
    chk_q.push_back('{1'b1, {7'h00, v}});
    pulse_chk();
  endtask : irq_is

  task automatic expect_rst(input int at, input int tol);
    rst_at.push_back(at);
    rst_tol.push_back(tol);
  endtask : expect_rst

  task automatic wait_rst();
    int n;
    n = 0;
    while (rst_at.size() != 0 && n < 4000) begin
      @(negedge ref_clk);
      n++;
    end
    if (rst_at.size() != 0) begin
      num_errors++;
      $display("CHECK FAILED wdt_reset_req expected cycle %0d seen none",
               rst_at[0]);
      report_and_stop();
    end
  endtask : wait_rst

  // One timer 0 pulse, one count-input fall, one clock rise per event
  task automatic src_ev(input int n);
    repeat (n) begin
      @(negedge ref_clk);
      timer0_ovf = 1'b1;
      ext_count_in = 1'b0;
      ext_clk_in = 1'b1;
      @(negedge ref_clk);
      timer0_ovf = 1'b0;
      ext_clk_in = 1'b0;
      @(negedge ref_clk);
      ext_count_in = 1'b1;
      repeat (2) @(negedge ref_clk);
    end
  endtask : src_ev

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  initial begin : main
    rnd = $urandom(29);
    repeat (4) @(negedge ref_clk);
    rst = 1'b0;
    expect_rst(WDT_FIRST_CYCLES, 0);
    rd(ADDR_CTRL, CTRL_RST);
    rd(ADDR_MODE, MODE_RST);
    rd(ADDR_CPL5, 8'h00);
    rd(8'h00, 8'h00);
    wait_rst();
    expect_rst(cyc + 2, 0);
    wr(ADDR_CTRL, 8'h20);
    rd(ADDR_CTRL, 8'h20);
    wr(ADDR_CTRL, 8'h00);
    wr(ADDR_MODE, 8'hff);
    rd(ADDR_MODE, 8'h40);
    wr(ADDR_MODE, 8'h00);
    rd(ADDR_MODE, 8'h00);
    wr(ADDR_MODE, 8'h10);
    rd(ADDR_MODE, 8'h00);
    // Inactive: flag only, any pulse here is a mismatch
    wr(ADDR_CTRL, 8'h20);
    rd(ADDR_CTRL, 8'h20);
    wr(ADDR_CTRL, 8'h00);
    for (int c = 0; c < 8; c++) begin
      rnd = $urandom;
      wr(ADDR_MODE, {4'h0, 3'(c), rnd[0]});
      rd(ADDR_MODE, {4'h0, 3'(c), rnd[0]});
    end
    foreach (tb_code[i]) begin
      wr(ADDR_CTRL, 8'h00);
      wr(ADDR_CNT_LO, 8'hfe);
      wr(ADDR_CNT_HI, 8'hff);
      wr(ADDR_MODE, {4'h0, tb_code[i], 1'b1});
      rd(ADDR_CTRL, 8'h00);
      irq_is(1'b0);
      wr(ADDR_CTRL, 8'h40);
      if (tb_n[i] == 2) begin
        src_ev(1);
        rd(ADDR_CTRL, 8'h40);
      end
      src_ev(tb_n[i] == 2 ? 1 : tb_n[i]);
      repeat (4) @(negedge ref_clk);
      rd(ADDR_CTRL, 8'hc0);
      irq_is(1'b1);
    end
    wr(ADDR_MODE, 8'h08);
    irq_is(1'b0);
    rd(ADDR_CTRL, 8'hc0);
    wr(ADDR_CTRL, 8'h00);
    // Watchdog with offset 2, counter held at 0x1000 until enabled
    wr(ADDR_CNT_LO, 8'h00);
    wr(ADDR_CNT_HI, 8'h10);
    wr(ADDR_CPL5, 8'h02);
    wr(ADDR_MODE, 8'h48);
    n0 = cyc;
    expect_rst(n0 + 768, 3);
    wr(ADDR_CPH5, 8'($urandom));
    wr(ADDR_CNT_HI, 8'h00);
    rd(ADDR_CPH5, 8'h12);
    wait_rst();
    wr(ADDR_MODE, 8'h08);
    rd(ADDR_MODE, 8'h08);
    @(negedge ref_clk);
    module_match = 5'h01;
    @(negedge ref_clk);
    module_match = 5'h00;
    rd(ADDR_CTRL, 8'h01);
    irq_is(1'b0);
    module_irq_en = 5'h04;
    module_match = 5'h04;
    @(negedge ref_clk);
    module_match = 5'h00;
    rd(ADDR_CTRL, 8'h05);
    irq_is(1'b1);
    wr(ADDR_CTRL, 8'h00);
    wr(ADDR_CNT_LO, 8'hf0);
    wr(ADDR_CNT_HI, 8'hff);
    wr(ADDR_MODE, 8'h89);
    cpu_idle = 1'b1;
    wr(ADDR_CTRL, 8'h40);
    repeat (40) @(negedge ref_clk);
    rd(ADDR_CTRL, 8'h40);
    cpu_idle = 1'b0;
    repeat (40) @(negedge ref_clk);
    rd(ADDR_CTRL, 8'hc0);
    wr(ADDR_MODE, 8'h08);
    wr(ADDR_CTRL, 8'h00);
    wr(ADDR_MODE, 8'h60);
    wr(ADDR_MODE, 8'h00);
    rd(ADDR_MODE, 8'h60);
    wr(ADDR_MODE, 8'h28);
    rd(ADDR_MODE, 8'h60);
    expect_rst(cyc + 2, 0);
    wr(ADDR_CTRL, 8'h20);
    wait_rst();
    @(negedge ref_clk);
    rst = 1'b1;
    repeat (4) @(negedge ref_clk);
    rst = 1'b0;
    rd(ADDR_MODE, MODE_RST);
    report_and_stop();
  end

endmodule : caw_wdt_ctrl_test

`default_nettype wire
